// File: verilog/bsd_pkg.sv
/*
  Package of the boot strap decoder: strap bit positions, decoded setting
  types, register offsets and reset values.
  Assumes a 32-bit APB register bus and a sixteen-lane strap input group.
*/
`default_nettype none

package bsd_pkg;

  // ****************************************************************
  // Strap layout
  // ****************************************************************
  localparam int          BSD_STRAP_W        = 16;
  localparam int          BSD_STRAP_STALL    = 0;
  localparam int          BSD_STRAP_LANE_REV = 2;
  localparam int          BSD_STRAP_EDP      = 4;
  localparam int          BSD_STRAP_SPLIT_LO = 5;
  localparam logic [15:0] BSD_STRAP_DEFAULT  = 16'hffff;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] BSD_OFS_CTRL     = 12'h000;
  localparam logic [11:0] BSD_OFS_STRAPS   = 12'h004;
  localparam logic [11:0] BSD_OFS_SETTINGS = 12'h008;
  localparam logic [11:0] BSD_OFS_STATUS   = 12'h00c;
  localparam logic [11:0] BSD_OFS_LIVE     = 12'h010;

  localparam int BSD_CTRL_RELEASE = 0;
  localparam int BSD_STAT_STATE   = 0;
  localparam int BSD_STAT_LOCK    = 4;
  localparam int BSD_STAT_CHANGED = 5;
  localparam int BSD_STAT_IN_RST  = 6;

  localparam logic [31:0] BSD_CTRL_RESET = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    BSD_SPLIT_NONE = 2'b00,
    BSD_SPLIT_RSVD = 2'b01,
    BSD_SPLIT_X8X2 = 2'b10,
    BSD_SPLIT_X16  = 2'b11
  } bsd_split_t;

  typedef enum logic [2:0] {
    BSD_ST_HOLD  = 3'b000,
    BSD_ST_LOCK  = 3'b001,
    BSD_ST_STALL = 3'b010,
    BSD_ST_RUN   = 3'b011
  } bsd_state_t;

  typedef enum logic [2:0] {
    BSD_SEL_CTRL     = 3'b000,
    BSD_SEL_STRAPS   = 3'b001,
    BSD_SEL_SETTINGS = 3'b010,
    BSD_SEL_STATUS   = 3'b011,
    BSD_SEL_LIVE     = 3'b100,
    BSD_SEL_NONE     = 3'b111
  } bsd_sel_t;

  typedef struct packed {
    logic       stall_req;
    logic       lane_reverse;
    logic       edp_enable;
    bsd_split_t split;
  } bsd_settings_t;

endpackage

`default_nettype wire

// File: verilog/bsd_strap_latch.sv
/*
  Strap resolver and latch: resolves unterminated strap lanes to one,
  follows them while platform reset is low and freezes them at release.
  Assumes strap and reset inputs are synchronous to pclk.
*/
`timescale 1ns/1ps
`default_nettype none

module bsd_strap_latch
  import bsd_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   platform_reset_n,
  input  wire logic [BSD_STRAP_W-1:0] strap_level,
  input  wire logic [BSD_STRAP_W-1:0] strap_term,
  output logic      [BSD_STRAP_W-1:0] live_q,
  output logic      [BSD_STRAP_W-1:0] latched_q,
  output logic                        latch_pulse_q
);

  logic [BSD_STRAP_W-1:0] live_d;
  logic [BSD_STRAP_W-1:0] latched_d;
  logic                   latch_pulse_d;
  logic                   rst_seen_q;
  logic                   rst_seen_d;

  // ****************************************************************
  // Resolve and latch
  // ****************************************************************
  always_comb begin
    live_d        = strap_level | ~strap_term;  // [R1]
    latched_d     = latched_q;
    latch_pulse_d = 1'b0;
    rst_seen_d    = ~platform_reset_n;
    if (!platform_reset_n) begin
      latched_d = live_q;  // [R7]
    end else if (rst_seen_q) begin
      latched_d     = live_q;  // [R7]
      latch_pulse_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q        <= BSD_STRAP_DEFAULT;
      latched_q     <= BSD_STRAP_DEFAULT;
      latch_pulse_q <= 1'b0;
      rst_seen_q    <= 1'b0;
    end else begin
      live_q        <= live_d;
      latched_q     <= latched_d;
      latch_pulse_q <= latch_pulse_d;
      rst_seen_q    <= rst_seen_d;
    end
  end

endmodule

`default_nettype wire

// File: verilog/bsd_top.sv
/*
  Boot strap decoder top: decodes latched board straps into reset-sequence
  stall, lane reversal, display output enable and graphics link split, and
  exposes them over an APB slave.
  Assumes straps, platform reset and PLL lock are synchronous to pclk.
*/
// Our own choices: the APB register port and the register offsets.
// Overview of operation
// R1: Unterminated strap lanes read as one.
// R2: Strap zero low stalls sequence after lock.
// R3: Strap two low reverses x16 lane numbering.
// R4: Strap four low enables display output.
// R5: Straps six-five select link split mode.
// R6: Platform controller alone drives platform reset.
// R7: Straps latched at reset release, then frozen.
`timescale 1ns/1ps
`default_nettype none

module bsd_top
  import bsd_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   platform_reset_n,
  input  wire logic                   pll_locked,
  input  wire logic [BSD_STRAP_W-1:0] strap_level,
  input  wire logic [BSD_STRAP_W-1:0] strap_term,
  output logic                        seq_proceed,
  output logic                        seq_stalled,
  output logic                        lane_reverse,
  output logic                        edp_enable,
  output logic                        split_x16,
  output logic                        split_x8x2,
  output logic                        split_reserved
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic bsd_sel_t dec_addr(input logic [11:0] a);
    bsd_sel_t s;
    s = BSD_SEL_NONE;
    case (a)
      BSD_OFS_CTRL: begin
        s = BSD_SEL_CTRL;
      end
      BSD_OFS_STRAPS: begin
        s = BSD_SEL_STRAPS;
      end
      BSD_OFS_SETTINGS: begin
        s = BSD_SEL_SETTINGS;
      end
      BSD_OFS_STATUS: begin
        s = BSD_SEL_STATUS;
      end
      BSD_OFS_LIVE: begin
        s = BSD_SEL_LIVE;
      end
      default: begin
        s = BSD_SEL_NONE;
      end
    endcase
    return s;
  endfunction

  function automatic bsd_settings_t decode(input logic [BSD_STRAP_W-1:0] st);
    bsd_settings_t r;
    r.stall_req    = ~st[BSD_STRAP_STALL];                          // [R2]
    r.lane_reverse = ~st[BSD_STRAP_LANE_REV];                       // [R3]
    r.edp_enable   = ~st[BSD_STRAP_EDP];                            // [R4]
    r.split        = bsd_split_t'(st[BSD_STRAP_SPLIT_LO +: 2]);     // [R5]
    return r;
  endfunction

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic [BSD_STRAP_W-1:0] live_q;
  logic [BSD_STRAP_W-1:0] latched_q;
  logic                   latch_pulse_q;
  bsd_settings_t          cfg;

  // The platform reset is only ever sampled here; nothing in this block
  // drives it, so a board-level short cannot be masked by the decoder.
  bsd_strap_latch u_latch (
    .pclk             (pclk),
    .presetn          (presetn),
    .platform_reset_n (platform_reset_n),  // [R6]
    .strap_level      (strap_level),
    .strap_term       (strap_term),
    .live_q           (live_q),
    .latched_q        (latched_q),
    .latch_pulse_q    (latch_pulse_q)
  );

  assign cfg = decode(latched_q);

  // ****************************************************************
  // Reset sequence state machine
  // ****************************************************************
  bsd_state_t state_q;
  bsd_state_t state_d;
  logic       proceed_q;
  logic       proceed_d;
  logic       stalled_q;
  logic       stalled_d;
  logic       release_q;
  logic       release_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      BSD_ST_HOLD: begin
        if (latch_pulse_q) begin
          state_d = BSD_ST_LOCK;
        end
      end
      BSD_ST_LOCK: begin
        if (pll_locked) begin
          state_d = cfg.stall_req ? BSD_ST_STALL : BSD_ST_RUN;  // [R2]
        end
      end
      BSD_ST_STALL: begin
        // The stall ends when the strap lane is let go or software
        // releases it, since test points may be unreachable in a chassis.
        if (live_q[BSD_STRAP_STALL] || release_q) begin
          state_d = BSD_ST_RUN;  // [R2]
        end
      end
      BSD_ST_RUN: begin
        state_d = BSD_ST_RUN;
      end
      default: begin
        state_d = BSD_ST_HOLD;
      end
    endcase
    if (!platform_reset_n) begin
      state_d = BSD_ST_HOLD;  // [R7]
    end
    proceed_d = (state_d == BSD_ST_RUN);
    stalled_d = (state_d == BSD_ST_STALL);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= BSD_ST_HOLD;
      proceed_q <= 1'b0;
      stalled_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      proceed_q <= proceed_d;
      stalled_q <= stalled_d;
    end
  end

  // ****************************************************************
  // Setting outputs
  // ****************************************************************
  logic lane_rev_q;
  logic lane_rev_d;
  logic edp_q;
  logic edp_d;
  logic x16_q;
  logic x16_d;
  logic x8_q;
  logic x8_d;
  logic rsvd_q;
  logic rsvd_d;

  // Outputs follow only the frozen copy, so they never move between
  // platform resets even if a strap is probed later.
  always_comb begin
    lane_rev_d = cfg.lane_reverse;                   // [R3] [R7]
    edp_d      = cfg.edp_enable;                     // [R4]
    x16_d      = (cfg.split == BSD_SPLIT_X16);       // [R5]
    x8_d       = (cfg.split == BSD_SPLIT_X8X2);      // [R5]
    rsvd_d     = ~x16_d & ~x8_d;                     // [R5]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_rev_q <= 1'b0;
      edp_q      <= 1'b0;
      x16_q      <= 1'b1;
      x8_q       <= 1'b0;
      rsvd_q     <= 1'b0;
    end else begin
      lane_rev_q <= lane_rev_d;
      edp_q      <= edp_d;
      x16_q      <= x16_d;
      x8_q       <= x8_d;
      rsvd_q     <= rsvd_d;
    end
  end

  // ****************************************************************
  // Strap change monitor
  // ****************************************************************
  logic changed_q;
  logic changed_d;
  logic chg_clr;

  // Set wins over a clear written in the same cycle.
  always_comb begin
    changed_d = changed_q;
    if (chg_clr) begin
      changed_d = 1'b0;
    end
    if (platform_reset_n && state_q != BSD_ST_HOLD && live_q != latched_q) begin
      changed_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      changed_q <= 1'b0;
    end else begin
      changed_q <= changed_d;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  bsd_sel_t    sel;
  logic        setup;
  logic        wr_fire;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        ready_d;
  logic        ready_q;
  logic        err_d;
  logic        err_q;

  assign sel     = dec_addr(paddr);
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & ready_q & pwrite;
  assign chg_clr = wr_fire && sel == BSD_SEL_STATUS && pwdata[BSD_STAT_CHANGED];

  always_comb begin
    release_d = release_q;
    if (wr_fire && sel == BSD_SEL_CTRL) begin
      release_d = pwdata[BSD_CTRL_RELEASE];
    end
    if (!platform_reset_n) begin
      release_d = BSD_CTRL_RESET[BSD_CTRL_RELEASE];
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (sel)
      BSD_SEL_CTRL: begin
        rdata_d[BSD_CTRL_RELEASE] = release_q;
      end
      BSD_SEL_STRAPS: begin
        rdata_d[BSD_STRAP_W-1:0] = latched_q;
      end
      BSD_SEL_SETTINGS: begin
        rdata_d[4:0] = cfg;
      end
      BSD_SEL_STATUS: begin
        rdata_d[BSD_STAT_STATE +: 3] = state_q;
        rdata_d[BSD_STAT_LOCK]       = pll_locked;
        rdata_d[BSD_STAT_CHANGED]    = changed_q;
        rdata_d[BSD_STAT_IN_RST]     = ~platform_reset_n;
      end
      BSD_SEL_LIVE: begin
        rdata_d[BSD_STRAP_W-1:0] = live_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
    ready_d = setup;
    err_d   = setup & (sel == BSD_SEL_NONE);
    if (!setup) begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_q <= BSD_CTRL_RESET[BSD_CTRL_RELEASE];
      rdata_q   <= 32'h0000_0000;
      ready_q   <= 1'b0;
      err_q     <= 1'b0;
    end else begin
      release_q <= release_d;
      rdata_q   <= rdata_d;
      ready_q   <= ready_d;
      err_q     <= err_d;
    end
  end

  // ****************************************************************
  // Output drive
  // ****************************************************************
  assign prdata         = rdata_q;
  assign pready         = ready_q;
  assign pslverr        = err_q;
  assign seq_proceed    = proceed_q;
  assign seq_stalled    = stalled_q;
  assign lane_reverse   = lane_rev_q;
  assign edp_enable     = edp_q;
  assign split_x16      = x16_q;
  assign split_x8x2     = x8_q;
  assign split_reserved = rsvd_q;

endmodule

`default_nettype wire

// File: verification/bsd_checker.sv
/*
  Checker of the boot strap decoder outputs against strap and reset inputs.
  Assumes it is bound to bsd_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module bsd_checker
  import bsd_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   platform_reset_n,
  input wire logic                   pll_locked,
  input wire logic [BSD_STRAP_W-1:0] strap_level,
  input wire logic [BSD_STRAP_W-1:0] strap_term,
  input wire logic                   seq_proceed,
  input wire logic                   seq_stalled,
  input wire logic                   lane_reverse,
  input wire logic                   edp_enable,
  input wire logic                   split_x16,
  input wire logic                   split_x8x2,
  input wire logic                   split_reserved
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Straps held for three cycles in platform reset, then release.
  sequence rel_s(c);
    (!platform_reset_n && c) [*3] ##1 platform_reset_n;
  endsequence

  unterm_one_a: assert property (rel_s(!strap_term[4]) |-> ##[1:4] !edp_enable)
    else $error("open lane did not read as one");
  stall_excl_a: assert property (!(seq_stalled && seq_proceed))
    else $error("stall and proceed together");
  lock_first_a: assert property (($rose(seq_proceed) && !$past(seq_stalled)) || $rose(seq_stalled) |-> $past(pll_locked))
    else $error("sequence moved before lock");
  lane_rev_a: assert property (rel_s(strap_term[2] && !strap_level[2]) |-> ##[1:4] lane_reverse)
    else $error("lane order not reversed");
  edp_on_a: assert property (rel_s(strap_term[4] && !strap_level[4]) |-> ##[1:4] edp_enable)
    else $error("display output not enabled");
  split_one_a: assert property ($onehot({split_x16, split_x8x2, split_reserved}))
    else $error("split outputs not one-hot");
  split_x8_a: assert property (rel_s(&strap_term[6:5] && strap_level[6:5] == 2'b10) |-> ##[1:4] split_x8x2)
    else $error("two by eight split missing");
  run_keep_a: assert property (seq_proceed && platform_reset_n |=> seq_proceed)
    else $error("run dropped without reset");
  cfg_frozen_a: assert property (seq_proceed && $past(seq_proceed) && platform_reset_n
      |-> $stable({lane_reverse, edp_enable, split_x16, split_x8x2, split_reserved}))
    else $error("settings changed after latch");
endmodule

bind bsd_top bsd_checker u_chk (.*);

`default_nettype wire

// File: verification/bsd_board_model.sv
/*
  Board model: strap resistors and the platform controller reset driver.
  Assumes the bench sets its requests right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module bsd_board_model
  import bsd_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic [BSD_STRAP_W-1:0] cfg,
  input  wire logic [BSD_STRAP_W-1:0] term,
  input  wire logic                   rst_req,
  input  wire logic                   lock_req,
  output logic      [BSD_STRAP_W-1:0] strap_level,
  output logic      [BSD_STRAP_W-1:0] strap_term,
  output logic                        platform_reset_n,
  output logic                        pll_locked
);
  logic phase = 1'b0;
  // Open lanes toggle every cycle so a decoder that reads them gets caught.
  always @(posedge pclk) begin
    phase <= ~phase;
    strap_level <= (cfg & term) | ({BSD_STRAP_W{phase}} & ~term);
    strap_term <= term;
    platform_reset_n <= ~rst_req;
    pll_locked <= lock_req;
  end
endmodule

`default_nettype wire

// File: verification/tb.sv
/*
  Self-checking bench of the boot strap decoder.
  Assumes the board model and the bound checker beside the design.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bsd_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic platform_reset_n, pll_locked, rst_req, lock_req;
  logic [15:0] strap_level, strap_term, cfg, term;
  logic seq_proceed, seq_stalled, lane_reverse, edp_enable, split_x16, split_x8x2, split_reserved;
  int err_count = 0, compares = 0;

  always #5 pclk = ~pclk;

  bsd_board_model u_board (.pclk(pclk), .cfg(cfg), .term(term), .rst_req(rst_req), .lock_req(lock_req),
    .strap_level(strap_level), .strap_term(strap_term), .platform_reset_n(platform_reset_n),
    .pll_locked(pll_locked));
  bsd_top DUT (.*);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The master only waits for the answer; a hang is ended by the watchdog.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Outputs expected from resolved straps; codes 00 and 01 both count as reserved.
  function automatic logic [31:0] exp_out(input logic [15:0] s);
    return {25'h0, s[0], ~s[0], ~s[2], ~s[4], s[6:5] == 2'b11, s[6:5] == 2'b10, ~s[6]};
  endfunction

  function automatic logic [31:0] outs();
    return {25'h0, seq_proceed, seq_stalled, lane_reverse, edp_enable, split_x16, split_x8x2, split_reserved};
  endfunction

  task automatic boot(input logic [15:0] c, input logic [15:0] t);
    int n;
    n = 0;
    rst_req <= 1'b1; lock_req <= 1'b0; cfg <= c; term <= t;
    repeat (5) @(posedge pclk);
    rst_req <= 1'b0;
    repeat (4) @(posedge pclk);
    lock_req <= 1'b1;
    while ((seq_proceed | seq_stalled) !== 1'b1 && n < 30) begin
      n++;
      @(posedge pclk);
    end
    chk({31'h0, seq_proceed | seq_stalled}, 32'h1);
    @(posedge pclk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_unterm;
    logic [31:0] rd; logic er;
    apb(1'b0, BSD_OFS_CTRL, 32'h0, rd, er);
    chk(rd, BSD_CTRL_RESET);
    boot(16'h0000, 16'h0000);
    chk(outs(), exp_out(16'hffff));
    apb(1'b0, BSD_OFS_STRAPS, 32'h0, rd, er);
    chk(rd, 32'h0000_ffff);
    $display("done: unterminated");
  endtask

  task automatic t_decode;
    logic [31:0] rd; logic er;
    boot(16'hffcb, 16'hffff);
    chk(outs(), exp_out(16'hffcb));
    apb(1'b0, BSD_OFS_SETTINGS, 32'h0, rd, er);
    chk(rd, 32'h0000_000e);
    $display("done: decode");
  endtask

  task automatic t_split;
    logic [15:0] c;
    for (int v = 0; v < 4; v++) begin
      c = {9'h1ff, 2'(v), 5'h1f};
      boot(c, 16'hffff);
      chk(outs(), exp_out(c));
    end
    $display("done: split");
  endtask

  task automatic t_stall;
    logic [31:0] rd; logic er;
    boot(16'hfffe, 16'hffff);
    chk(outs(), exp_out(16'hfffe));
    cfg <= 16'hffff;
    repeat (5) @(posedge pclk);
    chk(outs(), exp_out(16'hffff));
    cfg <= 16'hffef;
    repeat (5) @(posedge pclk);
    chk(outs(), exp_out(16'hffff));
    apb(1'b0, BSD_OFS_STATUS, 32'h0, rd, er);
    chk({30'h0, er, rd[BSD_STAT_CHANGED]}, 32'h1);
    chk({29'h0, rd[BSD_STAT_STATE +: 3]}, 32'(BSD_ST_RUN));
    apb(1'b1, BSD_OFS_STATUS, 32'h0000_0020, rd, er);
    apb(1'b0, BSD_OFS_STATUS, 32'h0, rd, er);
    chk({31'h0, rd[BSD_STAT_CHANGED]}, 32'h1);
    apb(1'b0, BSD_OFS_LIVE, 32'h0, rd, er);
    chk(rd, 32'h0000_ffef);
    apb(1'b0, BSD_OFS_STRAPS, 32'h0, rd, er);
    chk(rd, 32'h0000_fffe);
    boot(16'hfffe, 16'hffff);
    apb(1'b1, BSD_OFS_CTRL, 32'h1, rd, er);
    repeat (3) @(posedge pclk);
    chk(outs(), exp_out(16'hffff));
    apb(1'b0, 12'h020, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h8000_0000);
    $display("done: stall");
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic summarize();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    cfg = 16'hffff; term = 16'hffff; rst_req = 1'b1; lock_req = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_unterm();
    t_decode();
    t_split();
    t_stall();
    summarize();
  end

  // Whole run needs well under a thousand cycles.
  initial begin
    #200000;
    err_count++;
    summarize();
  end
endmodule

`default_nettype wire
